// file: hw/intr_cfg.svh
// offsets, field positions, implemented-bit mask and reset values for the interrupt block
`ifndef INTR_CFG_SVH
`define INTR_CFG_SVH
`define CORE_CTRL_ADDR 8'h0B
`define PERIPH_EN_ADDR 8'h8C
`define PERIPH_FLAG_ADDR 8'h0C
`define PERIPH_MASK_ADDR 8'h8D
`define GLOBAL_EN_BIT 7
`define PERIPH_GROUP_BIT 6
`define TZ_EN_BIT 5
`define EXTIE_BIT 4
`define PCIE_BIT 3
`define TZ_FLAG_BIT 2
`define EXTIF_BIT 1
`define PCIF_BIT 0
`define PERIPH_IMPL_MASK 8'hF7
`define CORE_RESET 8'h00
`define PERIPH_RESET 8'h00
`endif

// file: hw/intr_pkg.sv
// types shared by the interrupt enable and flag logic
package intr_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;
    typedef struct packed {
        logic timerZeroWrap;
        logic extEdge;
        logic portChange;
    } core_events_t;
endpackage

// file: hw/edge_select.sv
// edge detector for the external interrupt pin with selectable polarity
`timescale 1ns/1ps
module edge_select (
    input wire logic clk,
    input wire logic rst,
    input wire logic pinLevel,
    input wire logic risingSel,
    output logic edgeSeen
);
    logic lastLevel;

    // remember last level; reset value is low so no falling edge at startup
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lastLevel <= 1'b0;
        end else begin
            lastLevel <= pinLevel;
        end
    end

    // one-cycle pulse on the chosen transition
    assign edgeSeen = risingSel ? (pinLevel & ~lastLevel)
                                : (~pinLevel & lastLevel);
endmodule

// file: hw/interrupt_enable_flag_logic.sv
// core interrupt control, peripheral enables and flag logic
`timescale 1ns/1ps
`include "intr_cfg.svh"
module interrupt_enable_flag_logic
    import intr_pkg::*;
#(
    parameter int PORT_WIDTH = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire bus_req_t busReq,
    output logic [7:0] rdata,
    input wire logic timerZeroWrap,
    input wire logic externalInterruptPin,
    input wire logic edgeRising,
    input wire logic [PORT_WIDTH-1:0] portUpper,
    input wire logic [7:0] peripheralEvents,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////
    // register state
    logic [7:0] coreCtrl;
    logic [7:0] periphEn;
    logic [7:0] periphFlag;
    logic [7:0] periphMask;
    logic [PORT_WIDTH-1:0] lastPort;
    logic portSeeded;
    logic extEdge;
    logic portChange;
    logic wrCore;
    logic wrPeriphEn;
    logic wrPeriphFlag;
    logic wrPeriphMask;
    logic coreReq;
    logic periphReq;

    ////////////////////////////////////////////////////////////////////////
    // event detection
    edge_select extDetect (
        .clk(clk),
        .rst(rst),
        .pinLevel(externalInterruptPin),
        .risingSel(edgeRising),
        .edgeSeen(extEdge)
    );

    // the port snapshot is seeded once after reset so power-up levels
    // do not look like a change
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lastPort <= '0;
            portSeeded <= 1'b0;
        end else begin
            lastPort <= portUpper;
            portSeeded <= 1'b1;
        end
    end
    assign portChange = portSeeded && (portUpper != lastPort);

    ////////////////////////////////////////////////////////////////////////
    // address decode
    always_comb begin
        wrCore = 1'b0;
        wrPeriphEn = 1'b0;
        wrPeriphFlag = 1'b0;
        wrPeriphMask = 1'b0;
        if (busReq.wr && busReq.addr == `CORE_CTRL_ADDR) begin
            wrCore = 1'b1;
        end else if (busReq.wr && busReq.addr == `PERIPH_EN_ADDR) begin
            wrPeriphEn = 1'b1;
        end else if (busReq.wr && busReq.addr == `PERIPH_FLAG_ADDR) begin
            wrPeriphFlag = 1'b1;
        end else if (busReq.wr && busReq.addr == `PERIPH_MASK_ADDR) begin
            wrPeriphMask = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // core control: enables written directly, flags set by hardware
    // set wins over a clearing write in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            coreCtrl <= `CORE_RESET;
        end else begin
            if (wrCore) begin
                coreCtrl <= busReq.wdata;
            end
            if (timerZeroWrap) begin
                coreCtrl[`TZ_FLAG_BIT] <= 1'b1;
            end
            if (extEdge) begin
                coreCtrl[`EXTIF_BIT] <= 1'b1;
            end
            if (portChange) begin
                coreCtrl[`PCIF_BIT] <= 1'b1;
            end
        end
    end

    // peripheral enables; bit 3 is not stored so it always reads zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            periphEn <= `PERIPH_RESET;
        end else if (wrPeriphEn) begin
            periphEn <= busReq.wdata & `PERIPH_IMPL_MASK;
        end
    end

    // peripheral flags: sticky, cleared by writing one, set wins;
    // each bit is worked out alone so that clearing one flag never
    // disturbs an event that lands on another in the same cycle
    logic [7:0] next_periphFlag;
    logic [7:0] clearFlag;
    assign clearFlag = {8{wrPeriphFlag}} & busReq.wdata;
    for (genvar g = 0; g < 8; g++) begin : flagBit
        if (g == 3) begin : hole
            assign next_periphFlag[g] = 1'b0;
        end else begin : live
            assign next_periphFlag[g] = peripheralEvents[g]
                | (periphFlag[g] & ~clearFlag[g]);
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            periphFlag <= `PERIPH_RESET;
        end else begin
            periphFlag <= next_periphFlag;
        end
    end

    // extra mask over peripheral flags, all open but bit 3 after reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            periphMask <= `PERIPH_IMPL_MASK;
        end else if (wrPeriphMask) begin
            periphMask <= busReq.wdata & `PERIPH_IMPL_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request generation; enables gate only the request, never the flags
    logic [7:0] periphLive;
    // one term per core source, each enable beside its own flag
    assign coreReq =
        (coreCtrl[`TZ_EN_BIT] & coreCtrl[`TZ_FLAG_BIT]) |
        (coreCtrl[`EXTIE_BIT] & coreCtrl[`EXTIF_BIT]) |
        (coreCtrl[`PCIE_BIT] & coreCtrl[`PCIF_BIT]);
    // a peripheral source counts when enable, flag and mask agree
    assign periphLive = periphEn & periphFlag & periphMask;
    // the group bit stands in front of every peripheral source
    assign periphReq = coreCtrl[`PERIPH_GROUP_BIT] & (|periphLive);
    // the global bit is last, so one write silences every source;
    // a stale flag fires at once when its enable goes up
    assign irq = coreCtrl[`GLOBAL_EN_BIT] & (coreReq | periphReq);

    ////////////////////////////////////////////////////////////////////////
    // read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (busReq.rd && busReq.addr == `CORE_CTRL_ADDR) begin
            rdata <= coreCtrl;
        end else if (busReq.rd && busReq.addr == `PERIPH_EN_ADDR) begin
            rdata <= periphEn;
        end else if (busReq.rd && busReq.addr == `PERIPH_FLAG_ADDR) begin
            rdata <= periphFlag;
        end else if (busReq.rd && busReq.addr == `PERIPH_MASK_ADDR) begin
            rdata <= periphMask;
        end else begin
            rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    // each core source is raised when its enable and its flag are set
    sequence t0Raised;
        coreCtrl[`TZ_FLAG_BIT] && coreCtrl[`TZ_EN_BIT];
    endsequence
    sequence extRaised;
        coreCtrl[`EXTIF_BIT] && coreCtrl[`EXTIE_BIT];
    endsequence
    sequence portRaised;
        coreCtrl[`PCIF_BIT] && coreCtrl[`PCIE_BIT];
    endsequence
    // read strobes, each answered in the following cycle
    sequence coreRead;
        busReq.rd && busReq.addr == `CORE_CTRL_ADDR;
    endsequence
    sequence enRead;
        busReq.rd && busReq.addr == `PERIPH_EN_ADDR;
    endsequence
    sequence flagRead;
        busReq.rd && busReq.addr == `PERIPH_FLAG_ADDR;
    endsequence
    sequence maskRead;
        busReq.rd && busReq.addr == `PERIPH_MASK_ADDR;
    endsequence

    // hardware events land on the edge that ends their cycle
    t0_flag_set_a: assert property (@(posedge clk) disable iff (rst)
        timerZeroWrap |=> coreCtrl[`TZ_FLAG_BIT])
        else $error("timer zero flag not set");
    ext_flag_set_a: assert property (@(posedge clk) disable iff (rst)
        extEdge |=> coreCtrl[`EXTIF_BIT])
        else $error("external flag not set");
    port_flag_set_a: assert property (@(posedge clk) disable iff (rst)
        portChange |=> coreCtrl[`PCIF_BIT])
        else $error("port change flag not set");

    // the detectors must see the transitions they are asked for
    ext_rise_a: assert property (@(posedge clk) disable iff (rst)
        (portSeeded && edgeRising && externalInterruptPin
         && !$past(externalInterruptPin)) |-> extEdge)
        else $error("rising edge missed");
    ext_fall_a: assert property (@(posedge clk) disable iff (rst)
        (portSeeded && !edgeRising && !externalInterruptPin
         && $past(externalInterruptPin)) |-> extEdge)
        else $error("falling edge missed");
    port_detect_a: assert property (@(posedge clk) disable iff (rst)
        (portSeeded && portUpper != $past(portUpper)) |-> portChange)
        else $error("port change missed");

    // flags stay up until a write takes them down
    t0_flag_hold_a: assert property (@(posedge clk) disable iff (rst)
        (coreCtrl[`TZ_FLAG_BIT] && !wrCore) |=> coreCtrl[`TZ_FLAG_BIT])
        else $error("timer zero flag dropped");
    ext_flag_hold_a: assert property (@(posedge clk) disable iff (rst)
        (coreCtrl[`EXTIF_BIT] && !wrCore) |=> coreCtrl[`EXTIF_BIT])
        else $error("external flag dropped");
    port_flag_hold_a: assert property (@(posedge clk) disable iff (rst)
        (coreCtrl[`PCIF_BIT] && !wrCore) |=> coreCtrl[`PCIF_BIT])
        else $error("port change flag dropped");

    // a write with no event in flight stores the whole byte
    core_write_a: assert property (@(posedge clk) disable iff (rst)
        (wrCore && !timerZeroWrap && !extEdge && !portChange)
        |=> coreCtrl == $past(busReq.wdata))
        else $error("core control write lost");

    // bit 3 of the peripheral registers is never stored
    bit3_zero_a: assert property (@(posedge clk) disable iff (rst)
        !periphEn[3] && !periphFlag[3])
        else $error("unimplemented bit set");
    en_write_a: assert property (@(posedge clk) disable iff (rst)
        wrPeriphEn |=> periphEn == ($past(busReq.wdata) & `PERIPH_IMPL_MASK))
        else $error("enable write lost");
    en_hold_a: assert property (@(posedge clk) disable iff (rst)
        !wrPeriphEn |=> $stable(periphEn))
        else $error("enables moved without a write");
    mask_write_a: assert property (@(posedge clk) disable iff (rst)
        wrPeriphMask |=> periphMask == ($past(busReq.wdata) & 8'hF7))
        else $error("mask write lost");
    mask_hold_a: assert property (@(posedge clk) disable iff (rst)
        !wrPeriphMask |=> $stable(periphMask))
        else $error("mask moved without a write");

    // request gating, source by source and then globally
    t0_irq_a: assert property (@(posedge clk) disable iff (rst)
        (t0Raised and coreCtrl[`GLOBAL_EN_BIT]) |-> irq)
        else $error("timer zero interrupt missing");
    ext_irq_a: assert property (@(posedge clk) disable iff (rst)
        (extRaised and coreCtrl[`GLOBAL_EN_BIT]) |-> irq)
        else $error("external interrupt missing");
    port_irq_a: assert property (@(posedge clk) disable iff (rst)
        (portRaised and coreCtrl[`GLOBAL_EN_BIT]) |-> irq)
        else $error("port change interrupt missing");
    flag_ignores_en_a: assert property (@(posedge clk) disable iff (rst)
        (peripheralEvents[7] && !periphEn[7]) |=> periphFlag[7])
        else $error("flag gated by enable");
    global_block_a: assert property (@(posedge clk) disable iff (rst)
        !coreCtrl[`GLOBAL_EN_BIT] |-> !irq)
        else $error("interrupt with global enable low");
    irq_quiet_a: assert property (@(posedge clk) disable iff (rst)
        (!coreReq && !periphReq) |-> !irq)
        else $error("interrupt with no source");
    periph_gate_a: assert property (@(posedge clk) disable iff (rst)
        (!coreCtrl[`PERIPH_GROUP_BIT] && !coreReq) |-> !irq)
        else $error("peripheral interrupt with group off");
    group_off_a: assert property (@(posedge clk) disable iff (rst)
        !coreCtrl[`PERIPH_GROUP_BIT] |-> !periphReq)
        else $error("peripheral request with group off");
    eeprom_gate_a: assert property (@(posedge clk) disable iff (rst)
        (coreCtrl[`GLOBAL_EN_BIT] && coreCtrl[`PERIPH_GROUP_BIT]
         && periphEn[7] && periphFlag[7] && periphMask[7]) |-> irq)
        else $error("eeprom interrupt missing");

    // read data stand only in the cycle after the strobe
    read_core_a: assert property (@(posedge clk) disable iff (rst)
        coreRead |=> rdata == $past(coreCtrl))
        else $error("core control read wrong");
    read_en_a: assert property (@(posedge clk) disable iff (rst)
        enRead |=> rdata == $past(periphEn))
        else $error("enable read wrong");
    read_flag_a: assert property (@(posedge clk) disable iff (rst)
        flagRead |=> rdata == $past(periphFlag))
        else $error("flag read wrong");
    read_mask_a: assert property (@(posedge clk) disable iff (rst)
        maskRead |=> rdata == $past(periphMask))
        else $error("mask read wrong");
    read_idle_a: assert property (@(posedge clk) disable iff (rst)
        !busReq.rd |=> rdata == 8'h00)
        else $error("read data outside its cycle");

    // per-source peripheral checks; bit 3 has no source and is skipped
    // so that these never look at the hole in the layout
    for (genvar g = 0; g < 8; g++) begin : bitCheck
        if (g != 3) begin : live
            // an event sets its flag whatever the enables say
            pflag_set_a: assert property (
                @(posedge clk) disable iff (rst)
                peripheralEvents[g] |=> periphFlag[g])
                else $error("peripheral flag not set");
            // writing a one clears the flag unless an event wins
            pflag_clear_a: assert property (
                @(posedge clk) disable iff (rst)
                (wrPeriphFlag && busReq.wdata[g] && !peripheralEvents[g])
                |=> !periphFlag[g])
                else $error("peripheral flag not cleared");
            // nothing but a clearing write takes the flag down
            pflag_hold_a: assert property (
                @(posedge clk) disable iff (rst)
                (periphFlag[g] && !(wrPeriphFlag && busReq.wdata[g]))
                |=> periphFlag[g])
                else $error("peripheral flag dropped");
            // an enabled, flagged and unmasked source raises the line
            pen_gate_a: assert property (
                @(posedge clk) disable iff (rst)
                (coreCtrl[`GLOBAL_EN_BIT] && coreCtrl[`PERIPH_GROUP_BIT]
                 && periphLive[g]) |-> irq)
                else $error("peripheral interrupt missing");
            // a source whose enable is low never counts
            pen_block_a: assert property (
                @(posedge clk) disable iff (rst)
                !periphEn[g] |-> !periphLive[g])
                else $error("disabled source counted");
        end
    end
endmodule

// file: verification/test_interrupt_enable_flag_logic.sv
// register and event bench for the interrupt enable and flag logic
`timescale 1ns/1ps
`include "intr_cfg.svh"
module test_interrupt_enable_flag_logic
    import intr_pkg::*;
;
    logic clk;
    logic rst;
    bus_req_t busReq;
    logic [7:0] rdata;
    logic tzWrap;
    logic pin;
    logic rising;
    logic [3:0] port;
    logic [7:0] pev;
    logic irq;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;
    logic [7:0] b;

    interrupt_enable_flag_logic #(.PORT_WIDTH(4)) dut_u (
        .clk(clk), .rst(rst), .busReq(busReq), .rdata(rdata),
        .timerZeroWrap(tzWrap), .externalInterruptPin(pin),
        .edgeRising(rising), .portUpper(port),
        .peripheralEvents(pev), .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard; the ceiling is well above the few hundred
    // cycles that the sequence needs
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // compare, bus and event tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // strobe lowered at the edge that takes the write, so it lands first
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        busReq <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        busReq.wr <= 1'b0;
        #1;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        busReq <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        busReq.rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    task automatic pulse(input logic tz, input logic [7:0] ev);
        @(posedge clk);
        tzWrap <= tz;
        pev <= ev;
        @(posedge clk);
        tzWrap <= 1'b0;
        pev <= 8'h00;
        #1;
    endtask
    task automatic end_of_test();
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence; pin and port held still through reset so no
    // startup event is seen
    initial begin
        rst = 1'b1;
        busReq = '0;
        tzWrap = 1'b0;
        pin = 1'b0;
        rising = 1'b1;
        port = 4'h0;
        pev = 8'h00;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        idle(2);
        rdc(`CORE_CTRL_ADDR, 8'h00);
        rdc(`PERIPH_EN_ADDR, 8'h00);
        rdc(`PERIPH_MASK_ADDR, 8'hF7);
        wr(`PERIPH_EN_ADDR, 8'hFF);
        rdc(`PERIPH_EN_ADDR, 8'hF7);
        rdc(8'h55, 8'h00);
        wr(`PERIPH_EN_ADDR, 8'h00);
        $display("test registers done");
        pulse(1'b1, 8'hFF);
        rdc(`CORE_CTRL_ADDR, 8'h04);
        rdc(`PERIPH_FLAG_ADDR, 8'hF7);
        wr(`PERIPH_FLAG_ADDR, 8'hFF);
        rdc(`PERIPH_FLAG_ADDR, 8'h00);
        wr(`CORE_CTRL_ADDR, 8'h24);
        chk({7'h0, irq}, 8'h00);
        wr(`CORE_CTRL_ADDR, 8'hA4);
        chk({7'h0, irq}, 8'h01);
        idle(4);
        rdc(`CORE_CTRL_ADDR, 8'hA4);
        wr(`CORE_CTRL_ADDR, 8'hA0);
        chk({7'h0, irq}, 8'h00);
        $display("test timer zero done");
        wr(`CORE_CTRL_ADDR, 8'h90);
        @(posedge clk);
        pin <= 1'b1;
        idle(3);
        chk({7'h0, irq}, 8'h01);
        wr(`CORE_CTRL_ADDR, 8'h90);
        chk({7'h0, irq}, 8'h00);
        @(posedge clk);
        rising <= 1'b0;
        pin <= 1'b0;
        idle(3);
        rdc(`CORE_CTRL_ADDR, 8'h92);
        wr(`CORE_CTRL_ADDR, 8'h88);
        @(posedge clk);
        port <= 4'h8;
        idle(3);
        chk({7'h0, irq}, 8'h01);
        rdc(`CORE_CTRL_ADDR, 8'h89);
        wr(`CORE_CTRL_ADDR, 8'h08);
        chk({7'h0, irq}, 8'h00);
        $display("test pin and port done");
        // each peripheral source alone, gated by its enable and the group
        for (int i = 0; i < 8; i++) begin
            b = 8'h01 << i;
            if (i != 3) begin
                wr(`CORE_CTRL_ADDR, 8'hC0);
                wr(`PERIPH_EN_ADDR, b);
                pulse(1'b0, b);
                chk({7'h0, irq}, 8'h01);
                rdc(`PERIPH_FLAG_ADDR, b);
                wr(`CORE_CTRL_ADDR, 8'h80);
                chk({7'h0, irq}, 8'h00);
                wr(`CORE_CTRL_ADDR, 8'hC0);
                wr(`PERIPH_EN_ADDR, ~b & 8'hF7);
                chk({7'h0, irq}, 8'h00);
                wr(`PERIPH_FLAG_ADDR, b);
            end
        end
        // the extra mask holds back an enabled source until reopened
        wr(`CORE_CTRL_ADDR, 8'hC0);
        wr(`PERIPH_EN_ADDR, 8'h01);
        wr(`PERIPH_MASK_ADDR, 8'h00);
        pulse(1'b0, 8'h01);
        chk({7'h0, irq}, 8'h00);
        rdc(`PERIPH_MASK_ADDR, 8'h00);
        wr(`PERIPH_MASK_ADDR, 8'hFF);
        chk({7'h0, irq}, 8'h01);
        rdc(`PERIPH_MASK_ADDR, 8'hF7);
        wr(`PERIPH_FLAG_ADDR, 8'h01);
        chk({7'h0, irq}, 8'h00);
        $display("test peripheral done");
        end_of_test();
    end
endmodule
